// File: hw/bist_pkg.sv
package bist_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_TALLY     = 8'h15;
   localparam logic [7:0]  IDX_CONTROL   = 8'h16;
   localparam logic [7:0]  IDX_STATUS2   = 8'h17;
   localparam logic [9:0]  ADDR_TALLY    = 10'h054;
   localparam logic [9:0]  ADDR_CONTROL  = 10'h058;
   localparam logic [9:0]  ADDR_STATUS2  = 10'h05c;
   // Control register fields
   localparam int          POS_WRAP      = 15;
   localparam int          POS_PRBS_PKT  = 14;
   localparam int          POS_SIZE      = 13;
   localparam int          POS_GEN_ON    = 12;
   localparam int          POS_REV_FWD   = 7;
   localparam int          POS_MII_FWD   = 6;
   localparam int          POS_LOOP_LO   = 2;
   localparam logic [15:0] CONTROL_MASK  = 16'hf0ff;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   // Status register 2 fields
   localparam int          POS_SYNCED    = 11;
   localparam int          POS_DROPPED   = 10;
   localparam int          POS_BUSY      = 9;
   localparam int          POS_SCR_MST   = 8;
   localparam int          POS_SCR_SLV   = 7;
   localparam int          POS_AWAKE     = 6;
   // Loop point encodings
   localparam logic [3:0]  LOOP_REVERSE  = 4'h8;
   localparam logic [3:0]  LOOP_EXTERNAL = 4'h4;
   localparam logic [3:0]  LOOP_ANALOG   = 4'h2;
   localparam logic [3:0]  LOOP_DIGITAL  = 4'h1;
   // Coding loop encodings at 100 Mb/s
   localparam logic [1:0]  PCS_FULL      = 2'h3;
   localparam logic [1:0]  PCS_SCRAMBLED = 2'h2;
   localparam logic [1:0]  PCS_RAW       = 2'h1;
   localparam logic [15:0] TALLY_MAX     = 16'hffff;
   localparam logic [10:0] LEN_SHORT     = 11'd64;
   localparam logic [10:0] LEN_LONG      = 11'd1518;
   localparam logic [15:0] PRBS_CNT_MAX  = 16'hffff;
   localparam logic [7:0]  CONST_BYTE    = 8'h55;
   localparam logic [7:0]  IFG_BYTES     = 8'd12;
   localparam int          SYNC_NEED     = 8;
   typedef enum logic [1:0] {GEN_IDLE, GEN_DATA, GEN_GAP} gen_state_e;
endpackage : bist_pkg

// File: hw/phy_bist_loopback.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
module phy_bist_loopback
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        rx_dv,
   input  wire logic        rx_er,
   input  wire logic [7:0]  rx_data,
   input  wire logic        gig_speed,
   input  wire logic        gig_legacy_master,
   input  wire logic        gig_legacy_slave,
   input  wire logic        core_awake,
   output logic             gen_valid,
   output logic      [7:0]  gen_data,
   output logic      [3:0]  loop_point,
   output logic      [1:0]  coding_loop_select,
   output logic             gig_dsp_bypass,
   output logic             reverse_rx_forward,
   output logic             mii_tx_forward,
   output logic             prbs_wrap_pulse
);
   logic [15:0] ctrl_reg, ctrl_next;
   logic [15:0] tally_reg, tally_next;
   logic        err_seen_reg, err_seen_next;
   logic        dv_d_reg, dv_d_next;
   logic        wr_pend_reg, wr_pend_next;
   logic        rd_pend_reg, rd_pend_next;
   logic [9:0]  addr_reg, addr_next;
   logic [31:0] hrdata_next;
   bist_pkg::gen_state_e st_reg, st_next;
   logic [10:0] byte_cnt_reg, byte_cnt_next;
   logic [15:0] lfsr_reg, lfsr_next;
   logic [15:0] chk_reg, chk_next;
   logic [3:0]  match_reg, match_next;
   logic        synced_reg, synced_next;
   logic        dropped_reg, dropped_next;
   logic [15:0] pkt_cnt_reg, pkt_cnt_next;
   logic [15:0] err_cnt_reg, err_cnt_next;
   logic        pulse_next;
   logic        gen_valid_next;
   logic [7:0]  gen_data_next;
   logic [3:0]  loop_next;
   logic [1:0]  cloop_next;
   logic        bypass_next, revf_next, miif_next;
   logic        acc, status_rd, gen_prev_reg;
   logic [15:0] status_word;
   logic [10:0] pkt_len;
   logic [15:0] lfsr_step;
   logic [15:0] chk_step;
   logic [7:0]  exp_byte;

   assign acc = hsel & hready & htrans[1];
   assign pkt_len = ctrl_reg[bist_pkg::POS_SIZE] ? bist_pkg::LEN_SHORT
                                                : bist_pkg::LEN_LONG;
   assign status_rd = rd_pend_reg & (addr_reg == bist_pkg::ADDR_STATUS2);

   // LFSR advanced eight bits per byte, x^16+x^14+x^13+x^11+1
   always_comb
   begin
      lfsr_step = lfsr_reg;
      chk_step  = chk_reg;
      for (int i = 0; i < 8; i++)
      begin
         lfsr_step = {lfsr_step[14:0], lfsr_step[15] ^ lfsr_step[13]
                      ^ lfsr_step[12] ^ lfsr_step[10]};
         chk_step  = {chk_step[14:0], chk_step[15] ^ chk_step[13]
                      ^ chk_step[12] ^ chk_step[10]};
      end
      // Last two bytes form the state; next byte is its new low byte
      exp_byte = chk_step[7:0];
   end

   always_comb
   begin
      status_word = 16'h0000;
      status_word[bist_pkg::POS_SYNCED]  = synced_reg;
      status_word[bist_pkg::POS_DROPPED] = dropped_reg;
      status_word[bist_pkg::POS_BUSY]    = (st_reg != bist_pkg::GEN_IDLE);
      status_word[bist_pkg::POS_SCR_MST] = gig_legacy_master;
      status_word[bist_pkg::POS_SCR_SLV] = gig_legacy_slave;
      status_word[bist_pkg::POS_AWAKE]   = core_awake;
   end

   // Bus slave: zero wait states, write data taken in data phase
   always_comb
   begin
      wr_pend_next = acc & hwrite;
      rd_pend_next = acc & ~hwrite;
      addr_next    = acc ? haddr[9:0] : addr_reg;
      ctrl_next    = ctrl_reg;
      hrdata_next  = 32'h0000_0000;
      if (wr_pend_reg && addr_reg == bist_pkg::ADDR_CONTROL)
      begin
         ctrl_next = hwdata[15:0] & bist_pkg::CONTROL_MASK;
         if (ctrl_next[5:2] != bist_pkg::LOOP_REVERSE)
            ctrl_next[bist_pkg::POS_REV_FWD] = 1'b0;
         // TX forwarding only in MII (digital) loop
         if (ctrl_next[5:2] != bist_pkg::LOOP_DIGITAL)
            ctrl_next[bist_pkg::POS_MII_FWD] = 1'b0;
      end
      if (acc && !hwrite)
      begin
         case (haddr[9:0])
            bist_pkg::ADDR_TALLY:   hrdata_next = {16'h0000, tally_reg};
            bist_pkg::ADDR_CONTROL: hrdata_next = {16'h0000, ctrl_reg};
            bist_pkg::ADDR_STATUS2: hrdata_next = {16'h0000, status_word};
            default:                hrdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Receive error tally
   always_comb
   begin
      dv_d_next     = rx_dv;
      err_seen_next = err_seen_reg;
      tally_next    = tally_reg;
      if (rx_dv && rx_er)
         err_seen_next = 1'b1;
      // one count per errored frame at frame end
      if (dv_d_reg && !rx_dv)
      begin
         err_seen_next = 1'b0;
         if ((err_seen_reg || rx_er) && tally_reg != bist_pkg::TALLY_MAX)
            tally_next = tally_reg + 16'h0001;
      end
      if (wr_pend_reg && addr_reg == bist_pkg::ADDR_TALLY)
         tally_next = 16'h0000;
   end

   // Generator
   always_comb
   begin
      st_next        = st_reg;
      byte_cnt_next  = byte_cnt_reg;
      lfsr_next      = lfsr_reg;
      gen_valid_next = 1'b0;
      gen_data_next  = 8'h00;
      case (st_reg)
         bist_pkg::GEN_IDLE:
         begin
            byte_cnt_next = 11'd0;
            if (ctrl_reg[bist_pkg::POS_GEN_ON] && !gen_prev_reg)
               st_next = bist_pkg::GEN_DATA;
         end
         bist_pkg::GEN_DATA:
         begin
            gen_valid_next = 1'b1;
            if (ctrl_reg[bist_pkg::POS_PRBS_PKT])
            begin
               gen_data_next = lfsr_reg[15:8];
               lfsr_next     = lfsr_step;
            end
            else
               gen_data_next = bist_pkg::CONST_BYTE;
            byte_cnt_next = byte_cnt_reg + 11'd1;
            if (byte_cnt_reg == pkt_len - 11'd1)
            begin
               byte_cnt_next = 11'd0;
               st_next       = bist_pkg::GEN_GAP;
            end
            if (!ctrl_reg[bist_pkg::POS_GEN_ON])
               st_next = bist_pkg::GEN_IDLE;
         end
         bist_pkg::GEN_GAP:
         begin
            byte_cnt_next = byte_cnt_reg + 11'd1;
            if (byte_cnt_reg == {3'd0, bist_pkg::IFG_BYTES} - 11'd1)
            begin
               byte_cnt_next = 11'd0;
               st_next = (ctrl_reg[bist_pkg::POS_PRBS_PKT]
                          && ctrl_reg[bist_pkg::POS_GEN_ON])
                         ? bist_pkg::GEN_DATA : bist_pkg::GEN_IDLE;
            end
            if (!ctrl_reg[bist_pkg::POS_GEN_ON])
               st_next = bist_pkg::GEN_IDLE;
         end
         default: st_next = bist_pkg::GEN_IDLE;
      endcase
   end

   // Checker: self-synchronising on received bytes
   always_comb
   begin
      chk_next     = chk_reg;
      match_next   = match_reg;
      synced_next  = synced_reg;
      dropped_next = dropped_reg;
      pkt_cnt_next = pkt_cnt_reg;
      err_cnt_next = err_cnt_reg;
      pulse_next   = 1'b0;
      if (status_rd)
         dropped_next = 1'b0;
      // checker active when PRBS selected; idle otherwise
      if (ctrl_reg[bist_pkg::POS_PRBS_PKT] && rx_dv)
      begin
         chk_next = {chk_reg[7:0], rx_data};
         if (rx_data == exp_byte)
         begin
            if (match_reg != 4'(bist_pkg::SYNC_NEED))
               match_next = match_reg + 4'd1;
            else
               synced_next = 1'b1;
         end
         else
         begin
            match_next   = 4'd0;
            synced_next  = 1'b0;
            // latch on loss, set wins over read
            if (synced_reg)
               dropped_next = 1'b1;
            if (ctrl_reg[bist_pkg::POS_WRAP])
            begin
               if (err_cnt_reg == bist_pkg::PRBS_CNT_MAX)
               begin
                  err_cnt_next = 16'h0000;
                  pulse_next   = 1'b1;
               end
               else
                  err_cnt_next = err_cnt_reg + 16'h0001;
            end
            else if (err_cnt_reg != bist_pkg::PRBS_CNT_MAX)
               err_cnt_next = err_cnt_reg + 16'h0001;
         end
         if (ctrl_reg[bist_pkg::POS_WRAP])
         begin
            if (pkt_cnt_reg == bist_pkg::PRBS_CNT_MAX)
            begin
               pkt_cnt_next = 16'h0000;
               pulse_next   = 1'b1;
            end
            else
               pkt_cnt_next = pkt_cnt_reg + 16'h0001;
         end
         else if (pkt_cnt_reg != bist_pkg::PRBS_CNT_MAX)
            pkt_cnt_next = pkt_cnt_reg + 16'h0001;
      end
      if (!ctrl_reg[bist_pkg::POS_PRBS_PKT])
      begin
         match_next  = 4'd0;
         synced_next = 1'b0;
      end
   end

   // Loop controls
   always_comb
   begin
      loop_next  = ctrl_reg[5:2];
      cloop_next = ctrl_reg[1:0];
      bypass_next = gig_speed & ctrl_reg[0];
      revf_next = ctrl_reg[bist_pkg::POS_REV_FWD];
      miif_next = ctrl_reg[bist_pkg::POS_MII_FWD];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_reg           <= bist_pkg::CONTROL_RESET;
         tally_reg          <= 16'h0000;
         err_seen_reg       <= 1'b0;
         dv_d_reg           <= 1'b0;
         wr_pend_reg        <= 1'b0;
         rd_pend_reg        <= 1'b0;
         addr_reg           <= 10'h000;
         hrdata             <= 32'h0000_0000;
         hreadyout          <= 1'b1;
         hresp              <= 1'b0;
         st_reg             <= bist_pkg::GEN_IDLE;
         byte_cnt_reg       <= 11'd0;
         lfsr_reg           <= 16'hffff;
         chk_reg            <= 16'h0000;
         match_reg          <= 4'd0;
         synced_reg         <= 1'b0;
         dropped_reg        <= 1'b0;
         pkt_cnt_reg        <= 16'h0000;
         err_cnt_reg        <= 16'h0000;
         gen_prev_reg       <= 1'b0;
         prbs_wrap_pulse    <= 1'b0;
         gen_valid          <= 1'b0;
         gen_data           <= 8'h00;
         loop_point         <= 4'h0;
         coding_loop_select <= 2'h0;
         gig_dsp_bypass     <= 1'b0;
         reverse_rx_forward <= 1'b0;
         mii_tx_forward     <= 1'b0;
      end
      else
      begin
         ctrl_reg           <= ctrl_next;
         tally_reg          <= tally_next;
         err_seen_reg       <= err_seen_next;
         dv_d_reg           <= dv_d_next;
         wr_pend_reg        <= wr_pend_next;
         rd_pend_reg        <= rd_pend_next;
         addr_reg           <= addr_next;
         hrdata             <= hrdata_next;
         hreadyout          <= 1'b1;
         hresp              <= 1'b0;
         st_reg             <= st_next;
         byte_cnt_reg       <= byte_cnt_next;
         lfsr_reg           <= lfsr_next;
         chk_reg            <= chk_next;
         match_reg          <= match_next;
         synced_reg         <= synced_next;
         dropped_reg        <= dropped_next;
         pkt_cnt_reg        <= pkt_cnt_next;
         err_cnt_reg        <= err_cnt_next;
         gen_prev_reg       <= ctrl_reg[bist_pkg::POS_GEN_ON];
         prbs_wrap_pulse    <= pulse_next;
         gen_valid          <= gen_valid_next;
         gen_data           <= gen_data_next;
         loop_point         <= loop_next;
         coding_loop_select <= cloop_next;
         gig_dsp_bypass     <= bypass_next;
         reverse_rx_forward <= revf_next;
         mii_tx_forward     <= miif_next;
      end
   end
endmodule : phy_bist_loopback

// File: test/phy_bist_loopback_assertions.sv
`timescale 1ns/1ns
module phy_bist_loopback_assertions
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        gig_speed,
   input wire logic [3:0]  loop_point,
   input wire logic [1:0]  coding_loop_select,
   input wire logic        gig_dsp_bypass,
   input wire logic        reverse_rx_forward,
   input wire logic        mii_tx_forward,
   input wire logic        prbs_wrap_pulse
);
   logic       taken;
   logic       rd_dp;
   logic       wr_ctl;
   logic [9:0] dp_addr;

   assign taken = hsel & hready & htrans[1];

   // Data-phase tracking
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_dp   <= 1'b0;
         wr_ctl  <= 1'b0;
         dp_addr <= 10'h000;
      end
      else
      begin
         rd_dp   <= taken & !hwrite;
         wr_ctl  <= taken & hwrite &
                    (haddr[9:0] == bist_pkg::ADDR_CONTROL);
         dp_addr <= haddr[9:0];
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   ctl_reserved_a: assert property (rd_dp && dp_addr ==
      bist_pkg::ADDR_CONTROL |-> hrdata[31:16] == 16'h0 && hrdata[11:8] == 4'h0)
      else $error("control reserved bits not zero");
   sts_reserved_a: assert property (rd_dp && dp_addr ==
      bist_pkg::ADDR_STATUS2 |-> hrdata[15:12] == 4'h0 && hrdata[5:0] == 6'h0)
      else $error("status reserved bits not zero");
   loop_follow_a: assert property (wr_ctl |-> ##2
      loop_point == $past(hwdata[5:2], 2)) else $error("loop point not taken");
   coding_follow_a: assert property (wr_ctl |-> ##2
      coding_loop_select == $past(hwdata[1:0], 2))
      else $error("coding loop not taken");
   rev_guard_a: assert property (reverse_rx_forward |->
      loop_point == bist_pkg::LOOP_REVERSE) else $error("rx forward off mode");
   mii_guard_a: assert property (mii_tx_forward |->
      loop_point == bist_pkg::LOOP_DIGITAL) else $error("tx forward off mode");
   dsp_bypass_a: assert property ((gig_speed && coding_loop_select[0])[*2]
      |-> gig_dsp_bypass) else $error("gigabit bypass missing");
   no_bypass_a: assert property ((!gig_speed || !coding_loop_select[0])[*2]
      |-> !gig_dsp_bypass) else $error("gigabit bypass spurious");
   wrap_single_a: assert property (prbs_wrap_pulse |=> !prbs_wrap_pulse)
      else $error("wrap pulse too long");

   cover property (wr_ctl);
   cover property (rd_dp && dp_addr == bist_pkg::ADDR_STATUS2);
   cover property (prbs_wrap_pulse);
endmodule : phy_bist_loopback_assertions

bind phy_bist_loopback phy_bist_loopback_assertions
   phy_bist_loopback_assertions_inst (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hwdata, .hrdata, .gig_speed, .loop_point,
   .coding_loop_select, .gig_dsp_bypass, .reverse_rx_forward,
   .mii_tx_forward, .prbs_wrap_pulse);

// File: test/mac_loop_model.sv
`timescale 1ns/1ns
module mac_loop_model
(
   input  wire logic       hclk,
   input  wire logic       gen_valid,
   input  wire logic [7:0] gen_data,
   input  wire logic       send_err,
   input  wire logic       corrupt,
   output logic            rx_dv,
   output logic            rx_er,
   output logic      [7:0] rx_data
);
   initial
   begin
      rx_dv   = 1'b0;
      rx_er   = 1'b0;
      rx_data = 8'h00;
   end

   // Loops generated bytes back; idle line toggles between the inverted and the true last byte
   always @(posedge hclk)
   begin
      rx_dv   <= gen_valid | send_err;
      rx_er   <= send_err;
      rx_data <= (gen_valid | send_err) ? gen_data ^ {8{corrupt}} : ~rx_data;
   end
endmodule : mac_loop_model

// File: test/phy_bist_loopback_error_count_bench.sv
`timescale 1ns/1ns
module phy_bist_loopback_error_count_bench;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, coding_loop_select;
   logic [2:0]  hsize;
   logic [7:0]  rx_data, gen_data;
   logic [3:0]  loop_point;
   logic        rx_dv, rx_er, gig_speed, gig_legacy_master, gig_legacy_slave;
   logic        core_awake, gen_valid, gig_dsp_bypass, reverse_rx_forward;
   logic        mii_tx_forward, prbs_wrap_pulse, send_err, corrupt;
   int          miscompares, n_checks, n, i;

   assign hready = hreadyout;

   phy_bist_loopback phy_bist_loopback_inst (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
      .hresp, .rx_dv, .rx_er, .rx_data, .gig_speed, .gig_legacy_master,
      .gig_legacy_slave, .core_awake, .gen_valid, .gen_data, .loop_point,
      .coding_loop_select, .gig_dsp_bypass, .reverse_rx_forward,
      .mii_tx_forward, .prbs_wrap_pulse);
   mac_loop_model mac_loop_model_inst (.hclk, .gen_valid, .gen_data,
      .send_err, .corrupt, .rx_dv, .rx_er, .rx_data);

   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task complete_run;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   task check(input logic [31:0] got, input logic [31:0] exp, input string s);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
      end
   endtask : check

   task hung(input string s);
      miscompares++;
      $display("unexpected at %0t: %s timed out", $time, s);
      complete_run();
   endtask : hung

   task bus(input logic [9:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] r);
      int k;
      hsel   <= 1'b1;
      haddr  <= {22'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      k = 0;
      do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
      if (k >= 100)
         hung("bus");
      r = hrdata;
      check({31'h0, hresp}, 32'h0, "okay response");
   endtask : bus

   task wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask : wr

   task rdm(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      check(r & m, e, "register read");
   endtask : rdm

   task rd(input logic [9:0] a, input logic [31:0] e);
      rdm(a, 32'hffffffff, e);
   endtask : rd

   task count_run(input logic chk);
      for (i = 0; i < 3000 && gen_valid !== 1'b1; i++) @(posedge hclk);
      if (i == 3000)
         hung("packet start");
      n = 0;
      while (gen_valid === 1'b1 && n < 2000)
      begin
         if (chk)
            check({24'h0, gen_data}, 32'h55, "constant byte");
         n++;
         @(posedge hclk);
      end
   endtask : count_run

   task reset_values;
      rd(bist_pkg::ADDR_TALLY, 32'h0);
      rd(bist_pkg::ADDR_CONTROL, 32'h0);
      rd(bist_pkg::ADDR_STATUS2, 32'h0140);
      rd(10'h060, 32'h0);
      gig_legacy_master <= 1'b0;
      gig_legacy_slave  <= 1'b1;
      core_awake        <= 1'b0;
      repeat (3) @(posedge hclk);
      rd(bist_pkg::ADDR_STATUS2, 32'h0080);
      gig_legacy_slave  <= 1'b0;
      core_awake        <= 1'b1;
      repeat (3) @(posedge hclk);
   endtask : reset_values

   task tally_frames;
      repeat (3)
      begin
         send_err <= 1'b1;
         repeat (5) @(posedge hclk);
         send_err <= 1'b0;
         repeat (5) @(posedge hclk);
      end
      rd(bist_pkg::ADDR_TALLY, 32'h3);
      wr(bist_pkg::ADDR_TALLY, 32'h0000beef);
      rd(bist_pkg::ADDR_TALLY, 32'h0);
   endtask : tally_frames

   task control_fields;
      logic [3:0] codes [4];
      codes = '{4'h8, 4'h4, 4'h2, 4'h1};
      wr(bist_pkg::ADDR_CONTROL, 32'hffff0fff);
      rd(bist_pkg::ADDR_CONTROL, 32'h003f);
      wr(bist_pkg::ADDR_CONTROL, 32'h003c);
      foreach (codes[j])
      begin
         wr(bist_pkg::ADDR_CONTROL, {26'h3, codes[j], 2'b00});
         rd(bist_pkg::ADDR_CONTROL, {24'h0, codes[j] == 4'h8,
            codes[j] == 4'h1, codes[j], 2'b00});
         check(loop_point, codes[j], "loop point");
         check(reverse_rx_forward, codes[j] == 4'h8, "rx forward");
         check(mii_tx_forward, codes[j] == 4'h1, "tx forward");
      end
      wr(bist_pkg::ADDR_CONTROL, 32'h0);
      gig_speed <= 1'b1;
      for (i = 1; i < 4; i++)
      begin
         wr(bist_pkg::ADDR_CONTROL, i);
         repeat (3) @(posedge hclk);
         check(coding_loop_select, i, "coding loop");
         check(gig_dsp_bypass, i % 2, "dsp bypass");
      end
      gig_speed <= 1'b0;
      repeat (3) @(posedge hclk);
      check(gig_dsp_bypass, 0, "dsp bypass at low speed");
      wr(bist_pkg::ADDR_CONTROL, 32'h0);
   endtask : control_fields

   task single_packets;
      wr(bist_pkg::ADDR_CONTROL, 32'h3000);
      count_run(1'b1);
      check(n, 64, "short length");
      rd(bist_pkg::ADDR_STATUS2, 32'h0240);
      repeat (20) @(posedge hclk);
      rd(bist_pkg::ADDR_STATUS2, 32'h0040);
      for (i = 0; i < 200; i++)
      begin
         @(posedge hclk);
         if (gen_valid !== 1'b0)
            check(gen_valid, 0, "second packet");
      end
      wr(bist_pkg::ADDR_CONTROL, 32'h0);
      wr(bist_pkg::ADDR_CONTROL, 32'h1000);
      count_run(1'b1);
      check(n, 1518, "long length");
      wr(bist_pkg::ADDR_CONTROL, 32'h0);
   endtask : single_packets

   task prbs_stream;
      wr(bist_pkg::ADDR_CONTROL, 32'hf000);
      count_run(1'b0);
      count_run(1'b0);
      check(n, 64, "prbs length");
      rdm(bist_pkg::ADDR_STATUS2, 32'h0e00, 32'h0a00);
      for (i = 0; i < 100 && gen_valid !== 1'b1; i++) @(posedge hclk);
      if (i == 100)
         hung("prbs packet");
      repeat (10) @(posedge hclk);
      corrupt <= 1'b1;
      @(posedge hclk);
      corrupt <= 1'b0;
      repeat (4) @(posedge hclk);
      rdm(bist_pkg::ADDR_STATUS2, 32'h0400, 32'h0400);
      rdm(bist_pkg::ADDR_STATUS2, 32'h0400, 32'h0000);
      wr(bist_pkg::ADDR_CONTROL, 32'hc000);
      repeat (100) @(posedge hclk);
      rdm(bist_pkg::ADDR_STATUS2, 32'h0200, 32'h0000);
   endtask : prbs_stream

   task wrap_pulse;
      wr(bist_pkg::ADDR_CONTROL, 32'hd000);
      for (i = 0; i < 72000 && prbs_wrap_pulse !== 1'b1; i++) @(posedge hclk);
      if (i == 72000)
         hung("wrap pulse");
      @(posedge hclk);
      check(prbs_wrap_pulse, 0, "wrap pulse width");
      wr(bist_pkg::ADDR_CONTROL, 32'h0);
   endtask : wrap_pulse

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      gig_speed = 1'b0;
      gig_legacy_master = 1'b1;
      gig_legacy_slave = 1'b0;
      core_awake = 1'b1;
      send_err = 1'b0;
      corrupt = 1'b0;
      miscompares = 0;
      n_checks = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      reset_values();
      tally_frames();
      control_fields();
      single_packets();
      prbs_stream();
      wrap_pulse();
      complete_run();
   end
endmodule : phy_bist_loopback_error_count_bench
